// *** rtl/capture_timer_pkg.sv ***
package capture_timer_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int IDX_W = 15;
  localparam logic [14:0] LOW_MATCH_DATA_IDX = 15'h7F18;
  localparam logic [14:0] HIGH_MATCH_DATA_IDX = 15'h7F19;
  localparam logic [14:0] LOW_COUNTER_IDX = 15'h7F1A;
  localparam logic [14:0] HIGH_COUNTER_IDX = 15'h7F1B;
  localparam logic [14:0] FIRST_CONTROL_IDX = 15'h7F1C;
  localparam logic [14:0] CAPTURE_CONTROL_IDX = 15'h7F1D;
  localparam logic [14:0] CLOCK_CONTROL_IDX = 15'h7F1E;

  // ----------------------------------------------------------------
  // first control register fields
  // ----------------------------------------------------------------
  localparam int HIGH_COUNT_ENABLE_BIT = 7;
  localparam int HIGH_MATCH_FLAG_BIT = 6;
  localparam int HIGH_IRQ_ENABLE_BIT = 5;
  localparam int SPLIT_MODE_SELECT_BIT = 4;
  localparam int CAPTURE_READ_SELECT_BIT = 3;
  localparam int LOW_COUNT_ENABLE_BIT = 2;
  localparam int LOW_MATCH_FLAG_BIT = 1;
  localparam int LOW_IRQ_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // capture control and clock control fields
  // ----------------------------------------------------------------
  localparam int CAPTURE_SOURCE_SELECT_LSB = 3;
  localparam int HIGH_CAPTURE_FLAG_BIT = 2;
  localparam int LOW_CAPTURE_FLAG_BIT = 1;
  localparam int CAPTURE_IRQ_ENABLE_BIT = 0;
  localparam int COUNT_CLOCK_SELECT_LSB = 6;
  localparam int EVENT_INPUT_SELECT_BIT = 5;
  localparam int DIVIDER_LIMIT_LSB = 0;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [1:0] CLK_SYSTEM = 2'h0;
  localparam logic [1:0] CLK_EVENT = 2'h1;
  localparam logic [1:0] CLK_OSC_A = 2'h2;
  localparam logic [1:0] CLK_OSC_B = 2'h3;
  localparam int NUM_EVENTS = 6;
  localparam int NUM_SYNC = 8;
  localparam int OSC_A_SYNC = 6;
  localparam int OSC_B_SYNC = 7;

endpackage : capture_timer_pkg

// *** rtl/edge_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module edge_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous pin and its rising-edge pulse
  input wire logic pin_i,
  output logic rise_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two flops against metastability, a third for the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // one-cycle strobe per rising edge
  assign rise_o = sync_reg & ~last_reg;

endmodule : edge_sync

`default_nettype wire

// *** rtl/match_buffer.sv ***
`timescale 1ns/10ps
`default_nettype none

module match_buffer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic at_zero_i,
  input wire logic [7:0] data_i,
  // buffered compare value
  output logic [7:0] buf_o
);

  // follow the data while stopped, reload only at count zero while running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_o <= 8'h00;
    end else if (!run_i) begin
      buf_o <= data_i;
    end else if (at_zero_i) begin
      buf_o <= data_i;
    end
  end

endmodule : match_buffer

`default_nettype wire

// *** rtl/capture_timer.sv ***
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module capture_timer
  import capture_timer_pkg::*;
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // avalon-mm slave
  input wire logic [16:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // external event and oscillator pins
  input wire logic [5:0] EXT_EVENT_I,
  input wire logic OSC_SOURCE_A_I,
  input wire logic OSC_SOURCE_B_I,
  // interrupt request
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_rise;
  logic [5:0] ev;
  logic [7:0] low_match_data_reg;
  logic [7:0] high_match_data_reg;
  logic [7:0] first_control_reg;
  logic [7:0] capture_control_reg;
  logic [7:0] clock_control_reg;
  logic [3:0] prescale_reg;
  logic [7:0] low_counter_reg;
  logic [7:0] high_counter_reg;
  logic [7:0] low_capture_reg;
  logic [7:0] high_capture_reg;
  logic [7:0] low_buf;
  logic [7:0] high_buf;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic irq_reg;
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [14:0] idx;
  logic be0;
  logic split_mode;
  logic low_enable;
  logic high_enable;
  logic capture_read;
  logic [1:0] count_clock_select;
  logic event_input_select;
  logic [3:0] divider_limit;
  logic [1:0] capture_source_select;
  logic prescale_run;
  logic prescale_tick;
  logic prescale_match;
  logic low_run;
  logic high_run;
  logic low_tick;
  logic high_tick;
  logic low_equal;
  logic low_match;
  logic low_overflow;
  logic high_match;
  logic low_cap_req;
  logic high_cap_req;
  logic low_flag_set;
  logic high_flag_set;
  logic low_cap_flag_set;
  logic high_cap_flag_set;
  logic [7:0] read_mux;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {OSC_SOURCE_B_I, OSC_SOURCE_A_I, EXT_EVENT_I};

  // every pin gets its own two-flop synchroniser and edge strobe
  generate
    for (genvar g = 0; g < NUM_SYNC; g++) begin : g_sync
      edge_sync u_sync (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .pin_i(pin_raw[g]),
        .rise_o(pin_rise[g])
      );
    end
  endgenerate

  assign ev = pin_rise[NUM_EVENTS-1:0];

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  assign split_mode = first_control_reg[SPLIT_MODE_SELECT_BIT];
  assign low_enable = first_control_reg[LOW_COUNT_ENABLE_BIT];
  assign high_enable = first_control_reg[HIGH_COUNT_ENABLE_BIT];
  assign capture_read = first_control_reg[CAPTURE_READ_SELECT_BIT];
  assign count_clock_select = clock_control_reg[COUNT_CLOCK_SELECT_LSB +: 2];
  assign event_input_select = clock_control_reg[EVENT_INPUT_SELECT_BIT];
  assign divider_limit = clock_control_reg[DIVIDER_LIMIT_LSB +: 4];
  assign capture_source_select = capture_control_reg[CAPTURE_SOURCE_SELECT_LSB +: 2];

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  assign prescale_run = low_enable | (split_mode & high_enable);

  // count clock choice; split mode on the first event pin falls back to sysclk
  always_comb begin
    unique case (count_clock_select)
      CLK_SYSTEM: prescale_tick = 1'b1;
      CLK_EVENT: begin
        if (event_input_select) begin
          prescale_tick = ev[3];
        end else if (split_mode) begin
          prescale_tick = 1'b1;
        end else begin
          prescale_tick = ev[2];
        end
      end
      CLK_OSC_A: prescale_tick = pin_rise[OSC_A_SYNC];
      CLK_OSC_B: prescale_tick = pin_rise[OSC_B_SYNC];
    endcase
  end

  assign prescale_match = prescale_run & prescale_tick & (prescale_reg == divider_limit);

  // divider count; a limit of n gives one match every n+1 ticks
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      prescale_reg <= PRESCALE_RESET;
    end else if (!prescale_run || prescale_match) begin
      prescale_reg <= PRESCALE_RESET;
    end else if (prescale_tick) begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // low and high counters
  // ----------------------------------------------------------------
  assign low_run = low_enable;
  assign high_run = split_mode ? high_enable : low_enable;

  // low counter steps straight on the first event pin in split event mode
  assign low_tick = low_run &
    ((split_mode && count_clock_select == CLK_EVENT) ? ev[2] : prescale_match);

  // combined mode needs all sixteen bits equal before either half clears
  assign low_equal = split_mode ? (low_counter_reg == low_buf) :
    ({high_counter_reg, low_counter_reg} == {high_buf, low_buf});
  assign low_match = low_tick & low_equal;
  assign low_overflow = low_tick & ~low_equal & (low_counter_reg == 8'hFF);

  assign high_tick = high_run & (split_mode ? prescale_match : low_overflow);
  assign high_match = split_mode ? (high_tick & (high_counter_reg == high_buf)) :
    low_match;

  // low counter is an up counter, never written by software
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      low_counter_reg <= REG_RESET;
    end else if (!low_run || low_match) begin
      low_counter_reg <= REG_RESET;
    end else if (low_tick) begin
      low_counter_reg <= low_counter_reg + 8'h01;
    end
  end

  // high counter clears with the combined match in sixteen-bit mode
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      high_counter_reg <= REG_RESET;
    end else if (!high_run || high_match) begin
      high_counter_reg <= REG_RESET;
    end else if (high_tick) begin
      high_counter_reg <= high_counter_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // match buffers; software keeps to one write per period on slow clocks
  // ----------------------------------------------------------------
  match_buffer u_low_buf (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .run_i(low_run),
    .at_zero_i(low_counter_reg == 8'h00),
    .data_i(low_match_data_reg),
    .buf_o(low_buf)
  );

  match_buffer u_high_buf (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .run_i(high_run),
    .at_zero_i(high_counter_reg == 8'h00),
    .data_i(high_match_data_reg),
    .buf_o(high_buf)
  );

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // source pick for both capture requests
  always_comb begin
    unique case (capture_source_select)
      2'h0: begin
        low_cap_req = ev[0];
        high_cap_req = split_mode ? ev[1] : ev[0];
      end
      2'h1: begin
        low_cap_req = ev[2];
        high_cap_req = split_mode ? ev[3] : ev[2];
      end
      2'h2: begin
        low_cap_req = ev[4];
        high_cap_req = split_mode ? ev[5] : ev[4];
      end
      2'h3: begin
        low_cap_req = ev[5];
        high_cap_req = split_mode ? ev[4] : ev[5];
      end
    endcase
  end

  // snapshot of the live counts
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      low_capture_reg <= REG_RESET;
      high_capture_reg <= REG_RESET;
    end else begin
      if (low_cap_req) begin
        low_capture_reg <= low_counter_reg;
      end
      if (high_cap_req) begin
        high_capture_reg <= high_counter_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // flag set terms
  // ----------------------------------------------------------------
  // a match is the moment a running count equals its buffered value and clears to zero
  assign low_flag_set = low_match;
  assign high_flag_set = split_mode & high_match;
  assign low_cap_flag_set = low_cap_req;
  assign high_cap_flag_set = split_mode & high_cap_req;

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the ack cycle
  // ----------------------------------------------------------------
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
  assign wr_en = AVS_WRITE_I & ack_reg;
  assign rd_en = AVS_READ_I & ~ack_reg;
  assign idx = AVS_ADDRESS_I[ADDR_W-1:2];
  assign be0 = AVS_BYTEENABLE_I[0];

  // ack pulses one cycle after the request appears
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // match data and clock control registers
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      low_match_data_reg <= REG_RESET;
      high_match_data_reg <= REG_RESET;
      clock_control_reg <= REG_RESET;
    end else if (wr_en && be0) begin
      if (idx == LOW_MATCH_DATA_IDX) begin
        low_match_data_reg <= AVS_WRITEDATA_I[7:0];
      end
      if (idx == HIGH_MATCH_DATA_IDX) begin
        high_match_data_reg <= AVS_WRITEDATA_I[7:0];
      end
      if (idx == CLOCK_CONTROL_IDX) begin
        clock_control_reg <= {AVS_WRITEDATA_I[7:5], 1'b0, AVS_WRITEDATA_I[3:0]};
      end
    end
  end

  // first control: hardware set of a flag wins over a software clear
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      first_control_reg <= REG_RESET;
    end else begin
      if (wr_en && be0 && idx == FIRST_CONTROL_IDX) begin
        first_control_reg <= AVS_WRITEDATA_I[7:0];
      end
      if (low_flag_set) begin
        first_control_reg[LOW_MATCH_FLAG_BIT] <= 1'b1;
      end
      if (high_flag_set) begin
        first_control_reg[HIGH_MATCH_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // capture control; upper three bits do not exist and read zero
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      capture_control_reg <= REG_RESET;
    end else begin
      if (wr_en && be0 && idx == CAPTURE_CONTROL_IDX) begin
        capture_control_reg <= {3'h0, AVS_WRITEDATA_I[4:0]};
      end
      if (low_cap_flag_set) begin
        capture_control_reg[LOW_CAPTURE_FLAG_BIT] <= 1'b1;
      end
      if (high_cap_flag_set) begin
        capture_control_reg[HIGH_CAPTURE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // read mux; counter addresses show captures when selected
  always_comb begin
    unique case (idx)
      LOW_MATCH_DATA_IDX: read_mux = low_match_data_reg;
      HIGH_MATCH_DATA_IDX: read_mux = high_match_data_reg;
      LOW_COUNTER_IDX: read_mux = capture_read ? low_capture_reg : low_counter_reg;
      HIGH_COUNTER_IDX: read_mux = capture_read ? high_capture_reg : high_counter_reg;
      FIRST_CONTROL_IDX: read_mux = first_control_reg;
      CAPTURE_CONTROL_IDX: read_mux = capture_control_reg;
      CLOCK_CONTROL_IDX: read_mux = clock_control_reg;
      default: read_mux = 8'h00;
    endcase
  end

  // read data sampled in the wait cycle, standing through the ack cycle
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      readdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      readdata_reg <= {24'h00_0000, read_mux};
    end
  end

  assign AVS_READDATA_O = readdata_reg;

  // ----------------------------------------------------------------
  // shared interrupt request
  // ----------------------------------------------------------------
  // registered so the line never glitches on flag writes
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (first_control_reg[LOW_MATCH_FLAG_BIT] & first_control_reg[LOW_IRQ_ENABLE_BIT])
        | (first_control_reg[HIGH_MATCH_FLAG_BIT] & first_control_reg[HIGH_IRQ_ENABLE_BIT])
        | ((capture_control_reg[LOW_CAPTURE_FLAG_BIT] | capture_control_reg[HIGH_CAPTURE_FLAG_BIT])
          & capture_control_reg[CAPTURE_IRQ_ENABLE_BIT]);
    end
  end

  assign IRQ_O = irq_reg;

endmodule : capture_timer

`default_nettype wire

// *** dv/capture_timer_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

module capture_timer_sva
  import capture_timer_pkg::*;
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // avalon-mm slave
  input wire logic [16:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // interrupt request
  input wire logic IRQ_O
);
  // ----------------------------------------------------------------
  // shadow of software writes
  // ----------------------------------------------------------------
  logic [14:0] idx;
  logic wr_ack, rd_ack, hi_run;
  logic [7:0] ctl_reg, cap_reg, clk_reg, lo_reg, hi_reg;
  logic [2:0] ien;
  assign idx = AVS_ADDRESS_I[16:2];
  assign wr_ack = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0];
  assign rd_ack = AVS_READ_I & ~AVS_WAITREQUEST_O;
  assign hi_run = ctl_reg[2] | (ctl_reg[4] & ctl_reg[7]);
  assign ien = {ctl_reg[5], ctl_reg[0], cap_reg[0]};

  // flags are set by hardware too, so only enables, selects, the divider limit and match data are trusted
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ctl_reg <= REG_RESET;
      cap_reg <= REG_RESET;
      clk_reg <= REG_RESET;
      lo_reg <= REG_RESET;
      hi_reg <= REG_RESET;
    end else if (wr_ack) begin
      case (idx)
        FIRST_CONTROL_IDX: ctl_reg <= AVS_WRITEDATA_I[7:0];
        CAPTURE_CONTROL_IDX: cap_reg <= AVS_WRITEDATA_I[7:0];
        CLOCK_CONTROL_IDX: clk_reg <= AVS_WRITEDATA_I[7:0];
        LOW_MATCH_DATA_IDX: lo_reg <= AVS_WRITEDATA_I[7:0];
        HIGH_MATCH_DATA_IDX: hi_reg <= AVS_WRITEDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  a_wait_one: assert property ($rose(AVS_READ_I | AVS_WRITE_I)
    |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("bus wait not one cycle");
  a_rd_upper: assert property (rd_ack |-> AVS_READDATA_O[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // two cycles of margin: a stopped counter clears one edge after the write
  a_low_stop: assert property (rd_ack && idx == LOW_COUNTER_IDX && !ctl_reg[3]
    && !ctl_reg[2] && !$past(ctl_reg[2], 2) |-> AVS_READDATA_O[7:0] == 8'h00)
    else $error("stopped low counter not zero");
  a_high_stop: assert property (rd_ack && idx == HIGH_COUNTER_IDX && !ctl_reg[3]
    && !hi_run && !$past(hi_run, 2) |-> AVS_READDATA_O[7:0] == 8'h00)
    else $error("stopped high counter not zero");
  a_lo_match: assert property (rd_ack && idx == LOW_MATCH_DATA_IDX
    |-> AVS_READDATA_O[7:0] == lo_reg) else $error("low match data lost");
  a_hi_match: assert property (rd_ack && idx == HIGH_MATCH_DATA_IDX
    |-> AVS_READDATA_O[7:0] == hi_reg) else $error("high match data lost");
  a_ctl_read: assert property (rd_ack && idx == FIRST_CONTROL_IDX
    |-> (AVS_READDATA_O[7:0] & 8'hBD) == (ctl_reg & 8'hBD)) else $error("control bad");
  a_clk_read: assert property (rd_ack && idx == CLOCK_CONTROL_IDX
    |-> AVS_READDATA_O[7:0] == {clk_reg[7:5], 1'b0, clk_reg[3:0]})
    else $error("clock control bad");
  a_irq_mask: assert property (ien == 3'h0 && $past(ien) == 3'h0 |-> !IRQ_O)
    else $error("irq with all enables off");

  c_irq: cover property (IRQ_O);
  c_cap_read: cover property (rd_ack && idx == LOW_COUNTER_IDX && ctl_reg[3]);
  c_split: cover property (wr_ack && idx == FIRST_CONTROL_IDX && ctl_reg[4]);
endmodule : capture_timer_sva

bind capture_timer capture_timer_sva u_sva (.MCLK_I, .SYS_RST_I, .AVS_ADDRESS_I,
  .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O,
  .AVS_WAITREQUEST_O, .IRQ_O);

`default_nettype wire

// *** dv/capture_timer_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module capture_timer_test
  import capture_timer_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus signals and design
  // ----------------------------------------------------------------
  logic clk, rst, rd, wr, waitreq, irq;
  logic [16:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [5:0] ev;
  logic [7:0] v;
  int mismatches = 0;
  int num_checks = 0;

  // oscillator pins tied low: only event pins and the system clock clock the timer here
  capture_timer u_dut (.MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .EXT_EVENT_I(ev),
    .OSC_SOURCE_A_I(1'b0), .OSC_SOURCE_B_I(1'b0), .IRQ_O(irq));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one avalon cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [14:0] i, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    be <= b;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    v = rdata[7:0];
    if (n >= 50) mismatches++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wrr(input logic [14:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hF);
  endtask : wrr

  task automatic rdc(input string nm, input logic [14:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00, 4'hF);
    chk(nm, v, e);
  endtask : rdc

  // pin edges kept two clocks apart, then time for the strobe to land
  task automatic pulse(input int n, input int k);
    repeat (k) begin
      @(posedge clk);
      ev[n] <= 1'b1;
      repeat (2) @(posedge clk);
      ev[n] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      rdc("reset value", LOW_MATCH_DATA_IDX + 15'(i), 8'h00);
    end
    wrr(LOW_MATCH_DATA_IDX, 8'hA5);
    rdc("low match data", LOW_MATCH_DATA_IDX, 8'hA5);
    bus(1'b1, HIGH_MATCH_DATA_IDX, 8'h3C, 4'hE);
    rdc("high match data", HIGH_MATCH_DATA_IDX, 8'h00);
    wrr(LOW_COUNTER_IDX, 8'hFF);
    rdc("low counter", LOW_COUNTER_IDX, 8'h00);
    wrr(15'h7F1F, 8'h55);
    rdc("unmapped", 15'h7F1F, 8'h00);
  endtask : t_regs

  // combined mode on event 2 edges, divider limit 1, low match 2: six events
  task automatic t_events();
    wrr(LOW_MATCH_DATA_IDX, 8'h02);
    wrr(CLOCK_CONTROL_IDX, 8'h41);
    wrr(FIRST_CONTROL_IDX, 8'h04);
    pulse(2, 3);
    rdc("low counter", LOW_COUNTER_IDX, 8'h01);
    pulse(3, 2);
    rdc("low counter", LOW_COUNTER_IDX, 8'h01);
    pulse(0, 1);
    wrr(FIRST_CONTROL_IDX, 8'h0C);
    rdc("low capture", LOW_COUNTER_IDX, 8'h01);
    rdc("high capture", HIGH_COUNTER_IDX, 8'h00);
    rdc("capture control", CAPTURE_CONTROL_IDX, 8'h02);
    pulse(2, 2);
    rdc("first control", FIRST_CONTROL_IDX, 8'h0C);
    pulse(2, 1);
    rdc("first control", FIRST_CONTROL_IDX, 8'h0E);
    chk("irq", {7'h00, irq}, 8'h00);
    wrr(FIRST_CONTROL_IDX, 8'h0F);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    wrr(FIRST_CONTROL_IDX, 8'h0D);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h00);
    wrr(CAPTURE_CONTROL_IDX, 8'h00);
    wrr(FIRST_CONTROL_IDX, 8'h00);
    rdc("low counter", LOW_COUNTER_IDX, 8'h00);
  endtask : t_events

  // split mode, high timer alone on the system clock
  task automatic t_split();
    wrr(CLOCK_CONTROL_IDX, 8'h00);
    wrr(HIGH_MATCH_DATA_IDX, 8'hFF);
    wrr(FIRST_CONTROL_IDX, 8'h90);
    rdc("low counter", LOW_COUNTER_IDX, 8'h00);
    pulse(1, 1);
    rdc("capture control", CAPTURE_CONTROL_IDX, 8'h04);
    wrr(FIRST_CONTROL_IDX, 8'h98);
    rdc("low capture", LOW_COUNTER_IDX, 8'h01);
    repeat (300) @(posedge clk);
    rdc("first control", FIRST_CONTROL_IDX, 8'hD8);
    wrr(CAPTURE_CONTROL_IDX, 8'h08);
    pulse(1, 1);
    rdc("capture control", CAPTURE_CONTROL_IDX, 8'h08);
    pulse(3, 1);
    rdc("capture control", CAPTURE_CONTROL_IDX, 8'h0C);
    wrr(FIRST_CONTROL_IDX, 8'h00);
    rdc("high counter", HIGH_COUNTER_IDX, 8'h00);
  endtask : t_split

  // combined mode, source 10: event 4 must load both halves, only the low flag sets
  task automatic t_capture();
    wrr(LOW_MATCH_DATA_IDX, 8'hFF);
    wrr(HIGH_MATCH_DATA_IDX, 8'h02);
    wrr(CAPTURE_CONTROL_IDX, 8'h10);
    wrr(FIRST_CONTROL_IDX, 8'h04);
    // about 300 sysclk ticks: high half is 1, well short of the 16-bit match
    repeat (300) @(posedge clk);
    pulse(4, 1);
    wrr(FIRST_CONTROL_IDX, 8'h08);
    rdc("high capture", HIGH_COUNTER_IDX, 8'h01);
    rdc("capture control", CAPTURE_CONTROL_IDX, 8'h12);
  endtask : t_capture

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // about a thousand cycles expected; the limit leaves wide margin
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 17'h00000;
    wdata = 32'h00000000;
    be = 4'h0;
    ev = 6'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_split();
    t_capture();
    end_sim();
  end
endmodule : capture_timer_test

`default_nettype wire
